// ===== rtl/adcpc_pkg.sv
// ****************************************************************
// Post-conversion compute constants
// ****************************************************************
package adcpc_pkg;
   localparam int RES_W  = 12;
   localparam int ACC_W  = 18;
   localparam int CNT_W  = 8;
   localparam int SH_W   = 3;
   localparam int MODE_W = 3;
   localparam int AW     = 8;
   localparam int BYTE_W = 8;

   // Largest 18-bit sum; compared against a 20-bit signed sum
   localparam logic [ACC_W+1:0] ACC_MAX = 20'h3FFFF;
   localparam logic [CNT_W-1:0] CNT_SAT = 8'hFF;

   // Accumulator clear duration in clock cycles
   localparam int CLR_CYCLES = 5;

   typedef enum logic [MODE_W-1:0] {
      MD_BASIC = 3'h0,
      MD_ACCUM = 3'h1,
      MD_AVG   = 3'h2,
      MD_BURST = 3'h3,
      MD_LPF   = 3'h4
   } adcpc_mode_t;

   // Register byte offsets
   localparam logic [AW-1:0] OFS_CTRL = 8'h00;
   localparam logic [AW-1:0] OFS_RPT  = 8'h04;
   localparam logic [AW-1:0] OFS_STAT = 8'h08;
   localparam logic [AW-1:0] OFS_ACCL = 8'h0C;
   localparam logic [AW-1:0] OFS_ACCH = 8'h10;
   localparam logic [AW-1:0] OFS_ACCU = 8'h14;
   localparam logic [AW-1:0] OFS_CNT  = 8'h18;
   localparam logic [AW-1:0] OFS_FLT  = 8'h1C;
   localparam logic [AW-1:0] OFS_RES  = 8'h20;

   // Control register fields
   localparam int CTL_MODE_LSB  = 0;
   localparam int CTL_SHIFT_LSB = 4;
   localparam int CTL_DSE_BIT   = 8;
   localparam int CTL_CLR_BIT   = 9;

   // Status register fields
   localparam int ST_DONE_BIT   = 0;
   localparam int ST_THR_BIT    = 1;
   localparam int ST_OVF_BIT    = 2;
   localparam int ST_SECOND_BIT = 3;
   localparam int ST_BUSY_BIT   = 4;

   // Reset values
   localparam logic [SH_W-1:0]  SHIFT_RST = 3'h0;
   localparam logic [CNT_W-1:0] RPT_RST   = 8'h00;
endpackage

// ===== rtl/adcpc_math.sv
`timescale 1ns/1ps
// ****************************************************************
// Accumulator datapath
// ****************************************************************
module adcpc_math (
   input  wire logic [adcpc_pkg::MODE_W-1:0] mode,    // Computation mode
   input  wire logic [adcpc_pkg::SH_W-1:0]   shift,   // Right shift count
   input  wire logic                         dse,     // Double sample enable
   input  wire logic [adcpc_pkg::RES_W-1:0]  res,     // Current result
   input  wire logic [adcpc_pkg::RES_W-1:0]  prev,    // Previous result
   input  wire logic [adcpc_pkg::ACC_W-1:0]  acc,     // Accumulator base
   output logic      [adcpc_pkg::ACC_W-1:0]  acc_nxt, // Updated accumulator
   output logic                              ovf,     // Sum above 18-bit range
   output logic      [adcpc_pkg::ACC_W-1:0]  scaled   // Shifted accumulator
);
   logic signed [adcpc_pkg::RES_W+1:0] term;
   logic signed [adcpc_pkg::ACC_W+1:0] sum;

   always_comb begin
      if (dse) begin
         term = $signed({2'b00, res}) - $signed({2'b00, prev});
      end else begin
         term = $signed({2'b00, res});
      end
      sum = $signed({2'b00, acc})
          + $signed({{(adcpc_pkg::ACC_W - adcpc_pkg::RES_W){term[adcpc_pkg::RES_W+1]}}, term});
      if (mode == adcpc_pkg::MD_LPF) begin
         sum = sum - $signed({2'b00, acc >> shift});
      end
      // Negative sums wrap; only the upper bound is flagged
      ovf     = sum > $signed(adcpc_pkg::ACC_MAX);
      acc_nxt = sum[adcpc_pkg::ACC_W-1:0];
      scaled  = acc_nxt >> shift;
   end
endmodule // adcpc_math

// ===== rtl/adcpc_clrseq.sv
`timescale 1ns/1ps
// ****************************************************************
// Accumulator clear sequencer
// ****************************************************************
module adcpc_clrseq (
   input  wire logic clk,   // Block clock
   input  wire logic rst,   // Async reset, active high
   input  wire logic start, // Begin a clear
   output logic      busy,  // Clear in progress
   output logic      done   // Last cycle of clear
);
   localparam int CW = $clog2(adcpc_pkg::CLR_CYCLES);
   localparam logic [CW-1:0] LAST = CW'(adcpc_pkg::CLR_CYCLES - 1);

   logic [CW-1:0] cnt_r;
   logic          busy_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_r <= 1'b0;
         cnt_r  <= '0;
      end else if (!busy_r && start) begin
         busy_r <= 1'b1;
         cnt_r  <= '0;
      end else if (busy_r) begin
         if (cnt_r == LAST) begin
            busy_r <= 1'b0;
         end
         cnt_r <= cnt_r + 1'b1;
      end
   end

   assign busy = busy_r;
   assign done = busy_r && (cnt_r == LAST);
endmodule // adcpc_clrseq

// ===== rtl/adcpc_top.sv
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
// ****************************************************************
// ****************************************************************
module adcpc_top (
   input  wire logic                          clk,           // 20 MHz clock
   input  wire logic                          rst,           // Async reset, active high
   input  wire logic [adcpc_pkg::AW-1:0]      paddr,         // APB address
   input  wire logic                          psel,          // APB select
   input  wire logic                          penable,       // APB enable
   input  wire logic                          pwrite,        // APB write
   input  wire logic [31:0]                   pwdata,        // APB write data
   output logic      [31:0]                   prdata,        // APB read data
   output logic                               pready,        // APB ready
   output logic                               pslverr,       // APB error
   input  wire logic                          trigger,       // Go or external start
   input  wire logic                          conv_valid,    // Conversion finished
   input  wire logic [adcpc_pkg::RES_W-1:0]   conv_result,   // Conversion result
   input  wire logic                          threshold_met, // Threshold condition
   output logic                               retrigger,     // Self-started conversion
   output logic                               threshold_test,       // Test performed
   output logic                               conversion_done_flag, // Done flag
   output logic                               threshold_irq_flag    // Threshold flag
);
   // ****************************************************************
   // Registers and state
   // ****************************************************************
   adcpc_pkg::adcpc_mode_t                computation_mode_select;
   logic [adcpc_pkg::SH_W-1:0]            shift_select_r;
   logic                                  double_sample_enable_r;
   logic                                  clr_req_r;
   logic [adcpc_pkg::CNT_W-1:0]           rpt_r;
   logic [adcpc_pkg::CNT_W-1:0]           cnt_r;
   logic [adcpc_pkg::ACC_W-1:0]           acc_r;
   logic [adcpc_pkg::ACC_W-1:0]           flt_r;
   logic [adcpc_pkg::RES_W-1:0]           res_r;
   logic                                  second_r;
   logic                                  done_r;
   logic                                  thr_r;
   logic                                  ovf_r;
   logic                                  retrig_r;
   logic                                  test_r;
   logic                                  pready_r;
   logic                                  pslverr_r;
   logic [31:0]                           prdata_r;
   logic [31:0]                           rd_data;
   logic                                  rd_hit;
   logic                                  acc_ph;
   logic                                  wr_en;
   logic                                  wr_ctrl;
   logic                                  wr_stat;
   logic                                  busy;
   logic                                  clr_done;
   logic                                  upd;
   logic                                  first_half;
   logic                                  trig_clr;
   logic                                  accumulating;
   logic                                  test_due;
   logic [adcpc_pkg::ACC_W-1:0]           acc_base;
   logic [adcpc_pkg::CNT_W-1:0]           cnt_base;
   logic [adcpc_pkg::CNT_W-1:0]           cnt_new;
   logic [adcpc_pkg::ACC_W-1:0]           m_acc;
   logic [adcpc_pkg::ACC_W-1:0]           m_scaled;
   logic                                  m_ovf;

   // ****************************************************************
   // APB slave
   // ****************************************************************
   assign acc_ph  = psel && penable;
   assign wr_en   = acc_ph && pwrite && pready_r;
   assign wr_ctrl = wr_en && (paddr == adcpc_pkg::OFS_CTRL);
   assign wr_stat = wr_en && (paddr == adcpc_pkg::OFS_STAT);

   // One wait state so read data can come from a flop
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready_r <= 1'b0;
      end else begin
         pready_r <= acc_ph && !pready_r;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata_r  <= 32'h00000000;
         pslverr_r <= 1'b0;
      end else if (acc_ph && !pready_r) begin
         prdata_r  <= pwrite ? 32'h00000000 : rd_data;
         pslverr_r <= !rd_hit;
      end
   end

   always_comb begin
      rd_data = 32'h00000000;
      rd_hit  = 1'b1;
      case (paddr)
         adcpc_pkg::OFS_CTRL: begin
            rd_data[adcpc_pkg::CTL_MODE_LSB +: adcpc_pkg::MODE_W] = computation_mode_select;
            rd_data[adcpc_pkg::CTL_SHIFT_LSB +: adcpc_pkg::SH_W]  = shift_select_r;
            rd_data[adcpc_pkg::CTL_DSE_BIT] = double_sample_enable_r;
            rd_data[adcpc_pkg::CTL_CLR_BIT] = clr_req_r;
         end
         adcpc_pkg::OFS_RPT:  rd_data[adcpc_pkg::CNT_W-1:0] = rpt_r;
         adcpc_pkg::OFS_STAT: begin
            rd_data[adcpc_pkg::ST_DONE_BIT]   = done_r;
            rd_data[adcpc_pkg::ST_THR_BIT]    = thr_r;
            rd_data[adcpc_pkg::ST_OVF_BIT]    = ovf_r;
            rd_data[adcpc_pkg::ST_SECOND_BIT] = second_r;
            rd_data[adcpc_pkg::ST_BUSY_BIT]   = busy;
         end
         adcpc_pkg::OFS_ACCL: rd_data[adcpc_pkg::BYTE_W-1:0] = acc_r[adcpc_pkg::BYTE_W-1:0];
         adcpc_pkg::OFS_ACCH: begin
            rd_data[adcpc_pkg::BYTE_W-1:0] = acc_r[2*adcpc_pkg::BYTE_W-1:adcpc_pkg::BYTE_W];
         end
         adcpc_pkg::OFS_ACCU: begin
            rd_data[adcpc_pkg::ACC_W-2*adcpc_pkg::BYTE_W-1:0] =
               acc_r[adcpc_pkg::ACC_W-1:2*adcpc_pkg::BYTE_W];
         end
         adcpc_pkg::OFS_CNT:  rd_data[adcpc_pkg::CNT_W-1:0] = cnt_r;
         adcpc_pkg::OFS_FLT:  rd_data[adcpc_pkg::ACC_W-1:0] = flt_r;
         adcpc_pkg::OFS_RES:  rd_data[adcpc_pkg::RES_W-1:0] = res_r;
         default:             rd_hit = 1'b0;
      endcase
   end

   // ****************************************************************
   // Control registers
   // ****************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         computation_mode_select <= adcpc_pkg::MD_BASIC;
         shift_select_r          <= adcpc_pkg::SHIFT_RST;
         double_sample_enable_r  <= 1'b0;
         rpt_r                   <= adcpc_pkg::RPT_RST;
      end else begin
         if (wr_ctrl) begin
            computation_mode_select <= adcpc_pkg::adcpc_mode_t'(
               pwdata[adcpc_pkg::CTL_MODE_LSB +: adcpc_pkg::MODE_W]);
            shift_select_r          <= pwdata[adcpc_pkg::CTL_SHIFT_LSB +: adcpc_pkg::SH_W];
            double_sample_enable_r  <= pwdata[adcpc_pkg::CTL_DSE_BIT];
         end
         if (wr_en && (paddr == adcpc_pkg::OFS_RPT)) begin
            rpt_r <= pwdata[adcpc_pkg::CNT_W-1:0];
         end
      end
   end

   // Writing zero never aborts a clear already requested
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clr_req_r <= 1'b0;
      end else begin
         clr_req_r <= (wr_ctrl && pwdata[adcpc_pkg::CTL_CLR_BIT])
                   || (clr_req_r && !clr_done);
      end
   end

   adcpc_clrseq u_clrseq (
      .clk   (clk),
      .rst   (rst),
      .start (clr_req_r),
      .busy  (busy),
      .done  (clr_done)
   );

   // ****************************************************************
   // Computation
   // ****************************************************************
   always_comb begin
      upd          = conv_valid && !busy;
      first_half   = double_sample_enable_r && !second_r;
      accumulating = computation_mode_select != adcpc_pkg::MD_BASIC;
      trig_clr     = trigger && !busy
                   && (((computation_mode_select == adcpc_pkg::MD_AVG) && (cnt_r >= rpt_r))
                   || (computation_mode_select == adcpc_pkg::MD_BURST));
      acc_base     = trig_clr ? '0 : acc_r;
      cnt_base     = trig_clr ? '0 : cnt_r;
      cnt_new      = (cnt_base == adcpc_pkg::CNT_SAT) ? cnt_base : cnt_base + 1'b1;
      if (computation_mode_select inside {adcpc_pkg::MD_BASIC, adcpc_pkg::MD_ACCUM}) begin
         test_due = upd && !first_half;
      end else begin
         test_due = upd && !first_half && (cnt_new >= rpt_r);
      end
   end

   adcpc_math u_math (
      .mode    (computation_mode_select),
      .shift   (shift_select_r),
      .dse     (double_sample_enable_r),
      .res     (conv_result),
      .prev    (res_r),
      .acc     (acc_base),
      .acc_nxt (m_acc),
      .ovf     (m_ovf),
      .scaled  (m_scaled)
   );

   // Conversions arriving during a clear are dropped
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_r <= '0;
         cnt_r <= '0;
         ovf_r <= 1'b0;
      end else if (clr_done) begin
         acc_r <= '0;
         cnt_r <= '0;
         ovf_r <= 1'b0;
      end else if (upd && accumulating) begin
         acc_r <= m_acc;
         cnt_r <= cnt_new;
         if (m_ovf) begin
            ovf_r <= 1'b1;
         end
      end else if (trig_clr) begin
         acc_r <= '0;
         cnt_r <= '0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         res_r    <= '0;
         second_r <= 1'b0;
      end else if (upd) begin
         res_r    <= conv_result;
         second_r <= first_half;
      end else if (!double_sample_enable_r) begin
         second_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flt_r <= '0;
      end else if (test_due && accumulating) begin
         flt_r <= (computation_mode_select == adcpc_pkg::MD_LPF) ? m_acc : m_scaled;
      end
   end

   // Hardware set wins over a software clear in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         done_r   <= 1'b0;
         thr_r    <= 1'b0;
         test_r   <= 1'b0;
         retrig_r <= 1'b0;
      end else begin
         done_r   <= (upd && (accumulating || !first_half))
                  || (done_r && !(wr_stat && pwdata[adcpc_pkg::ST_DONE_BIT]));
         thr_r    <= (test_due && threshold_met)
                  || (upd && accumulating && m_ovf)
                  || (thr_r && !(wr_stat && pwdata[adcpc_pkg::ST_THR_BIT]));
         test_r   <= test_due;
         retrig_r <= upd && (computation_mode_select == adcpc_pkg::MD_BURST)
                  && (first_half || (cnt_new < rpt_r));
      end
   end

   assign prdata               = prdata_r;
   assign pready               = pready_r;
   assign pslverr              = pslverr_r;
   assign retrigger            = retrig_r;
   assign threshold_test       = test_r;
   assign conversion_done_flag = done_r;
   assign threshold_irq_flag   = thr_r;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_clr_start;
      clr_req_r && !busy;
   endsequence

   sequence s_clr_run;
      busy [*5] ##1 (acc_r == '0 && cnt_r == '0 && !ovf_r && !clr_req_r);
   endsequence

   a_clear_seq_done: assert property (s_clr_start |=> s_clr_run)
      else $error("accumulator clear did not finish in five cycles");

   a_basic_hold: assert property (
      (upd && computation_mode_select == adcpc_pkg::MD_BASIC)
      |=> $stable(acc_r) && $stable(cnt_r))
      else $error("basic mode changed accumulator or count");

   a_accum_add: assert property (
      (upd && computation_mode_select == adcpc_pkg::MD_ACCUM && !double_sample_enable_r)
      |=> acc_r == adcpc_pkg::ACC_W'($past(acc_r) + $past(conv_result)))
      else $error("accumulate mode sum wrong");

   a_count_sat: assert property (
      (upd && computation_mode_select inside {adcpc_pkg::MD_ACCUM, adcpc_pkg::MD_LPF}
       && cnt_r == adcpc_pkg::CNT_SAT) |=> cnt_r == adcpc_pkg::CNT_SAT)
      else $error("sample count did not hold at saturation");

   a_avg_restart: assert property (
      (computation_mode_select == adcpc_pkg::MD_AVG && trigger && !busy
       && cnt_r >= rpt_r && !conv_valid) |=> cnt_r == '0 && acc_r == '0)
      else $error("average mode did not restart on trigger");

   a_burst_retrig: assert property (
      (upd && computation_mode_select == adcpc_pkg::MD_BURST && !double_sample_enable_r
       && cnt_new < rpt_r) |=> retrigger && !threshold_test)
      else $error("burst mode failed to retrigger");

   a_lpf_test: assert property (
      (upd && computation_mode_select == adcpc_pkg::MD_LPF && !double_sample_enable_r
       && cnt_new >= rpt_r) |=> threshold_test)
      else $error("low-pass mode missed a threshold test");

   a_dbl_first_quiet: assert property (
      (upd && double_sample_enable_r && !second_r) |=> !threshold_test && second_r)
      else $error("first of double pair performed a test");

   a_ovf_flag_set: assert property (
      (upd && accumulating && m_ovf) |=> ovf_r)
      else $error("overflow flag not set");

   a_ovf_irq: assert property ($rose(ovf_r) |-> threshold_irq_flag)
      else $error("overflow did not raise threshold flag");

   a_lpf_output: assert property (
      (threshold_test && computation_mode_select == adcpc_pkg::MD_LPF
       && $stable(computation_mode_select)) |-> flt_r == acc_r)
      else $error("low-pass output differs from filter value");
endmodule // adcpc_top

// ===== verif/adcpc_core_model.sv
`timescale 1ns/1ps
// ****************************
// Conversion core model
// ****************************
module adcpc_core_model #(
   parameter int LAT = 3
) (
   input  wire logic        clk,    // Block clock
   input  wire logic        rst,    // Async reset
   input  wire logic        start,  // Trigger or retrigger
   input  wire logic [11:0] value,  // Next result
   input  wire logic        thr,    // Comparator level
   output logic             valid,  // Result strobe
   output logic [11:0]      result, // Result bus
   output logic             met     // Threshold condition
);
   int cnt;
   // Bus toggles off the strobe so a stale value never looks valid
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
         valid <= 1'b0;
         result <= 12'hA5A;
         met <= 1'b0;
      end else begin
         valid <= 1'b0;
         result <= ~result;
         met <= ~met;
         if (start) cnt <= LAT;
         else if (cnt > 0) cnt <= cnt - 1;
         if (cnt == 1) begin
            valid <= 1'b1;
            result <= value;
            met <= thr;
         end
      end
   end
endmodule // adcpc_core_model

// ===== verif/testbench.sv
`timescale 1ns/1ps
// ****************************
// Compute block bench
// ****************************
module testbench;
   localparam logic [7:0] CT = adcpc_pkg::OFS_CTRL;
   localparam logic [7:0] ST = adcpc_pkg::OFS_STAT;
   localparam logic [7:0] AL = adcpc_pkg::OFS_ACCL;
   localparam logic [7:0] AH = adcpc_pkg::OFS_ACCH;
   localparam logic [7:0] CN = adcpc_pkg::OFS_CNT;
   localparam logic [7:0] FL = adcpc_pkg::OFS_FLT;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic        trig, cv, met, thr, retrig, ttest, done_f, thr_f;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [11:0] cres, val;
   int          bad_count, checks;
   adcpc_top adcpc_top_i (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .trigger(trig), .conv_valid(cv),
      .conv_result(cres), .threshold_met(met), .retrigger(retrig),
      .threshold_test(ttest), .conversion_done_flag(done_f),
      .threshold_irq_flag(thr_f));
   adcpc_core_model adcpc_core_model_i (.clk(clk), .rst(rst),
      .start(trig | retrig), .value(val), .thr(thr), .valid(cv),
      .result(cres), .met(met));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic wrap_up();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         bad_count++;
         wrap_up();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // Burst waits on the final test pulse, others on the result strobe
   task automatic conv(input logic [11:0] v, input logic t, input logic b);
      int n;
      @(posedge clk);
      val <= v;
      thr <= t;
      trig <= 1'b1;
      @(posedge clk);
      trig <= 1'b0;
      n = 0;
      while ((b ? ttest : cv) !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      if (n >= 100) begin
         bad_count++;
         wrap_up();
      end
      repeat (2) @(posedge clk);
   endtask
   // Clear lasts a fixed five cycles, so a fixed wait is safe
   task automatic clr(input logic [31:0] c);
      apb(1'b1, CT, c | 32'h200);
      repeat (8) @(posedge clk);
      apb(1'b1, ST, 32'h3);
   endtask
   initial begin
      {rst, psel, penable, pwrite, trig, thr} = 6'h20;
      {paddr, pwdata, val} = 52'h0;
      bad_count = 0;
      checks = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rchk(CT, 32'h0);
      rchk(ST, 32'h0);
      rchk(FL, 32'h0);
      apb(1'b0, 8'h24, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("reset test done");
      apb(1'b1, CT, 32'h21);
      conv(12'h123, 1'b1, 1'b0);
      conv(12'h456, 1'b0, 1'b0);
      rchk(AL, 32'h79);
      rchk(AH, 32'h05);
      rchk(CN, 32'h2);
      rchk(FL, 32'h15E);
      rchk(ST, 32'h3);
      chk({30'h0, thr_f, done_f}, 32'h3);
      clr(32'h21);
      rchk(CT, 32'h21);
      rchk(CN, 32'h0);
      $display("accumulate test done");
      // Run on past overflow until the count saturates
      for (int i = 0; i < 256; i++) begin
         conv(12'hFFF, 1'b0, 1'b0);
         if (i == 63) rchk(ST, 32'h1);
      end
      rchk(ST, 32'h7);
      rchk(CN, 32'hFF);
      rchk(adcpc_pkg::OFS_ACCU, 32'h3);
      $display("overflow test done");
      apb(1'b1, adcpc_pkg::OFS_RPT, 32'h4);
      rchk(adcpc_pkg::OFS_RPT, 32'h4);
      apb(1'b1, CT, 32'h23);
      conv(12'h100, 1'b0, 1'b1);
      rchk(AH, 32'h04);
      rchk(CN, 32'h4);
      rchk(FL, 32'h100);
      $display("burst test done");
      // Count is at target from the burst, so the first trigger restarts
      apb(1'b1, ST, 32'h3);
      apb(1'b1, CT, 32'h22);
      for (int i = 0; i < 4; i++) begin
         conv(12'h080, 1'b1, 1'b0);
         if (i == 0) rchk(CN, 32'h1);
         if (i == 0) rchk(ST, 32'h5);
      end
      rchk(ST, 32'h7);
      rchk(FL, 32'h80);
      rchk(AH, 32'h02);
      $display("average test done");
      apb(1'b1, adcpc_pkg::OFS_RPT, 32'h2);
      clr(32'h14);
      conv(12'h100, 1'b1, 1'b0);
      rchk(ST, 32'h1);
      conv(12'h100, 1'b1, 1'b0);
      rchk(ST, 32'h3);
      rchk(FL, 32'h180);
      $display("filter test done");
      apb(1'b1, CT, 32'h100);
      apb(1'b1, ST, 32'h3);
      conv(12'h200, 1'b1, 1'b0);
      rchk(ST, 32'h8);
      conv(12'h300, 1'b1, 1'b0);
      rchk(ST, 32'h3);
      rchk(CN, 32'h2);
      rchk(adcpc_pkg::OFS_RES, 32'h300);
      $display("double sample test done");
      wrap_up();
   end
endmodule // testbench
